/* design/cmr_pkg.sv */
// Constants, types and register map of the compare/move/reverse datapath slice
package cmr_pkg;

    // Data widths
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 32;

    // Register word indices (byte address = index * 4)
    localparam logic [2:0] IDX_FIRST_SRC = 3'h0;
    localparam logic [2:0] IDX_SECOND_SRC = 3'h1;
    localparam logic [2:0] IDX_SHIFT_AMT = 3'h2;
    localparam logic [2:0] IDX_DEST = 3'h3;
    localparam logic [2:0] IDX_CTRL = 3'h4;
    localparam logic [2:0] IDX_FLAGS = 3'h5;
    localparam logic [2:0] IDX_STATUS = 3'h6;
    localparam logic [2:0] IDX_BRANCH = 3'h7;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 4;

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // Operation codes carried in the control register
    typedef enum logic [4:0] {
        OP_COMPARE_SUBTRACT, OP_COMPARE_NEGATIVE_ADD, OP_COPY_OPERAND, OP_COPY_INVERTED,
        OP_COPY_WIDE_IMMEDIATE, OP_WRITE_UPPER_HALF, OP_BYTE_REVERSE_WORD, OP_BYTE_REVERSE_EACH_HALF,
        OP_BYTE_REVERSE_LOW_HALF_SIGNED, OP_BIT_REVERSE_WORD, OP_PARALLEL_SIGNED_ADD_HALVES,
        OP_PARALLEL_SIGNED_ADD_BYTES, OP_HALVING_SIGNED_ADD_HALVES, OP_HALVING_SIGNED_ADD_BYTES
    } cmr_op_t;

    typedef enum logic [1:0] {
        SH_LOGICAL_LEFT_SHIFT, SH_LOGICAL_RIGHT_SHIFT, SH_ARITH_RIGHT_SHIFT, SH_ROTATE_RIGHT
    } cmr_shift_t;

    // Condition codes
    localparam logic [3:0] CC_EQ = 4'h0;
    localparam logic [3:0] CC_NE = 4'h1;
    localparam logic [3:0] CC_CS = 4'h2;
    localparam logic [3:0] CC_CC = 4'h3;
    localparam logic [3:0] CC_MI = 4'h4;
    localparam logic [3:0] CC_PL = 4'h5;
    localparam logic [3:0] CC_VS = 4'h6;
    localparam logic [3:0] CC_VC = 4'h7;
    localparam logic [3:0] CC_HI = 4'h8;
    localparam logic [3:0] CC_LS = 4'h9;
    localparam logic [3:0] CC_GE = 4'hA;
    localparam logic [3:0] CC_LT = 4'hB;
    localparam logic [3:0] CC_GT = 4'hC;
    localparam logic [3:0] CC_LE = 4'hD;

    // Shift amount limits
    localparam logic [7:0] SHIFT_CLAMP = 8'h21;
    localparam logic [5:0] WORD_BITS = 6'h20;

    // Program status flags, reset value all clear
    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cmr_flags_t;

    // Control register layout, reset value all zero
    typedef struct packed {
        logic go;
        logic [9:0] rsvd_hi;
        logic [4:0] imm_shift;
        logic [1:0] rsvd_lo;
        logic dest_is_pc;
        logic shift_by_reg;
        logic [1:0] shift_type;
        logic [3:0] cond;
        logic set_flags;
        logic [4:0] op;
    } cmr_ctrl_t;

    // Status register layout (low bits)
    typedef struct packed {
        logic cond_failed;
        logic branch_taken;
        logic reg_written;
        logic executed;
    } cmr_status_t;

endpackage

/* design/cmr_alu.sv */
// Datapath slice: compares, moves, byte/bit reversal and lane adds behind an AHB-Lite slave
`timescale 1ns/1ps

// Contract
// - Compare subtracts flexible value from first source, sets flags, writes nothing.
// - Compare-negative adds flexible value to first source, sets flags, writes nothing.
// - Both compares always update N, Z, C and V.
// - Plain copy writes the shifted flexible value to the destination.
// - Wide immediate copy zero-extends 16 bits and never sets flags.
// - Register-amount shifted copy behaves like the matching shift operation.
// - Inverted copy writes the complement of the flexible value.
// - With flag suffix: N, Z from result, C from shifter, V kept.
// - Plain copy to PC branches to the value with bit zero cleared.
// - Upper-half write sets bits 31..16, keeps bits 15..0.
// - Upper-half write keeps all flags.
// - Word byte reverse swaps all four bytes.
// - Halfword byte reverse swaps bytes inside each halfword in place.
// - Signed low-half byte reverse swaps low bytes and sign-extends to 32 bits.
// - Bit reverse moves bit i to bit 31 minus i.
// - Parallel halfword add does two independent 16-bit adds.
// - Parallel byte add does four independent 8-bit adds.
// - Reverses and lane adds never change flags.
// - Every operation executes only when its condition holds on current flags.
// - Halving adds sum each lane and shift it right by one.
module cmr_alu (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [cmr_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [cmr_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [cmr_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Branch request to the fetch unit
    output logic branch_valid,
    output logic [cmr_pkg::DATA_W-1:0] branch_target
);
    import cmr_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] first_src;
        logic [DATA_W-1:0] second_src;
        logic [DATA_W-1:0] shift_amt;
        logic [DATA_W-1:0] dest;
        cmr_ctrl_t ctrl;
        cmr_flags_t flags;
        cmr_status_t status;
        logic [DATA_W-1:0] branch_target;
        logic branch_valid;
        logic [DATA_W-1:0] hrdata;
        logic wr_pend;
        logic [2:0] wr_idx;
    } cmr_state_t;

    cmr_state_t st_reg;
    cmr_state_t st_next;

    // Returns {carry, value} of a shifted operand
    function automatic logic [DATA_W:0] shift_op(input logic [DATA_W-1:0] v, input logic [1:0] ty,
                                                 input logic [7:0] amt, input logic cin, input logic rotate_through_carry);
        logic [DATA_W:0] t;
        logic [5:0] a;
        logic [4:0] r;
        logic [DATA_W-1:0] rv;
        a = (amt > SHIFT_CLAMP) ? SHIFT_CLAMP[5:0] : amt[5:0];
        r = amt[4:0];
        rv = (v >> r) | (v << (WORD_BITS - {1'b0, r}));
        t = {cin, v};
        if (rotate_through_carry) begin
            t = {v[0], cin, v[DATA_W-1:1]};
        end else if (amt != 8'h00) begin
            unique case (cmr_shift_t'(ty))
                SH_LOGICAL_LEFT_SHIFT: t = {1'b0, v} << a;
                SH_LOGICAL_RIGHT_SHIFT: begin
                    t = {v, 1'b0} >> a;
                    t = {t[0], t[DATA_W:1]};
                end
                SH_ARITH_RIGHT_SHIFT: begin
                    t = ($signed({v, 1'b0}) >>> a);
                    t = {t[0], t[DATA_W:1]};
                end
                SH_ROTATE_RIGHT: t = {rv[DATA_W-1], rv};
            endcase
        end
        return t;
    endfunction

    function automatic logic cond_holds(input logic [3:0] cc, input cmr_flags_t f);
        logic ok;
        unique case (cc)
            CC_EQ: ok = f.z;
            CC_NE: ok = !f.z;
            CC_CS: ok = f.c;
            CC_CC: ok = !f.c;
            CC_MI: ok = f.n;
            CC_PL: ok = !f.n;
            CC_VS: ok = f.v;
            CC_VC: ok = !f.v;
            CC_HI: ok = f.c && !f.z;
            CC_LS: ok = !f.c || f.z;
            CC_GE: ok = (f.n == f.v);
            CC_LT: ok = (f.n != f.v);
            CC_GT: ok = !f.z && (f.n == f.v);
            CC_LE: ok = f.z || (f.n != f.v);
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Lane-wise signed add, wrapping or halving
    function automatic logic [DATA_W-1:0] lane_add(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                                   input logic halves, input logic halve);
        logic [DATA_W-1:0] r;
        logic [HALF_W:0] h;
        logic [BYTE_W:0] y;
        r = '0;
        h = '0;
        y = '0;
        if (halves) begin
            for (int i = 0; i < DATA_W / HALF_W; i++) begin
                h = {a[HALF_W*i+HALF_W-1], a[HALF_W*i+:HALF_W]} + {b[HALF_W*i+HALF_W-1], b[HALF_W*i+:HALF_W]};
                r[HALF_W*i+:HALF_W] = halve ? h[HALF_W:1] : h[HALF_W-1:0];
            end
        end else begin
            for (int i = 0; i < DATA_W / BYTE_W; i++) begin
                y = {a[BYTE_W*i+BYTE_W-1], a[BYTE_W*i+:BYTE_W]} + {b[BYTE_W*i+BYTE_W-1], b[BYTE_W*i+:BYTE_W]};
                r[BYTE_W*i+:BYTE_W] = halve ? y[BYTE_W:1] : y[BYTE_W-1:0];
            end
        end
        return r;
    endfunction

    // Control word written in the current data phase
    cmr_ctrl_t exec_ctrl;
    logic exec_fire;
    logic cond_ok;
    logic [DATA_W:0] flex_shift;
    logic [DATA_W-1:0] flex_val;
    logic [DATA_W:0] cmp_sum;
    logic [DATA_W-1:0] alu_res;
    cmr_flags_t alu_flags;
    logic alu_wr;
    logic [DATA_W-1:0] bit_reverse_word;
    logic addr_ok;
    logic rd_take;
    logic wr_take;

    assign exec_ctrl = cmr_ctrl_t'(hwdata);
    assign exec_fire = st_reg.wr_pend && (st_reg.wr_idx == IDX_CTRL) && exec_ctrl.go;
    assign cond_ok = cond_holds(exec_ctrl.cond, st_reg.flags);

    // Flexible value: register-amount or immediate-amount shift of the second source
    assign flex_shift = shift_op(st_reg.second_src, exec_ctrl.shift_type,
                                 exec_ctrl.shift_by_reg ? st_reg.shift_amt[7:0] : {3'h0, exec_ctrl.imm_shift},
                                 st_reg.flags.c,
                                 !exec_ctrl.shift_by_reg && (exec_ctrl.shift_type == SH_ROTATE_RIGHT)
                                 && (exec_ctrl.imm_shift == 5'h00));
    assign flex_val = flex_shift[DATA_W-1:0];

    // Compare arithmetic: subtract via inverted addend and carry-in
    assign cmp_sum = (exec_ctrl.op == OP_COMPARE_SUBTRACT) ?
                     {1'b0, st_reg.first_src} + {1'b0, ~flex_val} + {{DATA_W{1'b0}}, 1'b1} :
                     {1'b0, st_reg.first_src} + {1'b0, flex_val};

    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            bit_reverse_word[DATA_W-1-i] = st_reg.first_src[i];
        end
    end

    always_comb begin
        alu_res = st_reg.dest;
        alu_flags = st_reg.flags;
        alu_wr = 1'b0;
        case (cmr_op_t'(exec_ctrl.op))
            OP_COMPARE_SUBTRACT: begin
                alu_flags.n = cmp_sum[DATA_W-1];
                alu_flags.z = (cmp_sum[DATA_W-1:0] == '0);
                alu_flags.c = cmp_sum[DATA_W];
                alu_flags.v = (st_reg.first_src[DATA_W-1] != flex_val[DATA_W-1])
                              && (cmp_sum[DATA_W-1] != st_reg.first_src[DATA_W-1]);
            end
            OP_COMPARE_NEGATIVE_ADD: begin
                alu_flags.n = cmp_sum[DATA_W-1];
                alu_flags.z = (cmp_sum[DATA_W-1:0] == '0);
                alu_flags.c = cmp_sum[DATA_W];
                alu_flags.v = (st_reg.first_src[DATA_W-1] == flex_val[DATA_W-1])
                              && (cmp_sum[DATA_W-1] != st_reg.first_src[DATA_W-1]);
            end
            OP_COPY_OPERAND, OP_COPY_INVERTED: begin
                alu_res = (exec_ctrl.op == OP_COPY_INVERTED) ? ~flex_val : flex_val;
                alu_wr = 1'b1;
                if (exec_ctrl.set_flags) begin
                    alu_flags.n = alu_res[DATA_W-1];
                    alu_flags.z = (alu_res == '0);
                    alu_flags.c = flex_shift[DATA_W];
                end
            end
            OP_COPY_WIDE_IMMEDIATE: begin
                alu_res = {{HALF_W{1'b0}}, st_reg.second_src[HALF_W-1:0]};
                alu_wr = 1'b1;
            end
            OP_WRITE_UPPER_HALF: begin
                alu_res = {st_reg.second_src[HALF_W-1:0], st_reg.dest[HALF_W-1:0]};
                alu_wr = 1'b1;
            end
            OP_BYTE_REVERSE_WORD: begin
                alu_res = {st_reg.first_src[7:0], st_reg.first_src[15:8],
                           st_reg.first_src[23:16], st_reg.first_src[31:24]};
                alu_wr = 1'b1;
            end
            OP_BYTE_REVERSE_EACH_HALF: begin
                alu_res = {st_reg.first_src[23:16], st_reg.first_src[31:24],
                           st_reg.first_src[7:0], st_reg.first_src[15:8]};
                alu_wr = 1'b1;
            end
            OP_BYTE_REVERSE_LOW_HALF_SIGNED: begin
                alu_res = {{HALF_W{st_reg.first_src[7]}}, st_reg.first_src[7:0], st_reg.first_src[15:8]};
                alu_wr = 1'b1;
            end
            OP_BIT_REVERSE_WORD: begin
                alu_res = bit_reverse_word;
                alu_wr = 1'b1;
            end
            OP_PARALLEL_SIGNED_ADD_HALVES, OP_PARALLEL_SIGNED_ADD_BYTES,
            OP_HALVING_SIGNED_ADD_HALVES, OP_HALVING_SIGNED_ADD_BYTES: begin
                alu_res = lane_add(st_reg.first_src, st_reg.second_src,
                                   (exec_ctrl.op == OP_PARALLEL_SIGNED_ADD_HALVES)
                                   || (exec_ctrl.op == OP_HALVING_SIGNED_ADD_HALVES),
                                   (exec_ctrl.op == OP_HALVING_SIGNED_ADD_HALVES)
                                   || (exec_ctrl.op == OP_HALVING_SIGNED_ADD_BYTES));
                alu_wr = 1'b1;
            end
            default: begin
                alu_wr = 1'b0;
            end
        endcase
    end

    // Address phase decode: only the low 32 bytes are mapped
    assign addr_ok = (haddr[ADDR_W-1:IDX_MSB+1] == '0);
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite && addr_ok;

    always_comb begin
        st_next = st_reg;
        st_next.branch_valid = 1'b0;
        st_next.wr_pend = 1'b0;
        // Data phase of a write
        if (st_reg.wr_pend) begin
            unique case (st_reg.wr_idx)
                IDX_FIRST_SRC: st_next.first_src = hwdata;
                IDX_SECOND_SRC: st_next.second_src = hwdata;
                IDX_SHIFT_AMT: st_next.shift_amt = hwdata;
                IDX_DEST: st_next.dest = hwdata;
                IDX_CTRL: st_next.ctrl = exec_ctrl;
                IDX_FLAGS: st_next.flags = cmr_flags_t'(hwdata[3:0]);
                default: st_next.wr_pend = 1'b0;
            endcase
        end
        // Execute when the control word carries the go bit
        if (exec_fire) begin
            st_next.ctrl.go = 1'b0;
            st_next.status = '0;
            st_next.status.executed = cond_ok;
            st_next.status.cond_failed = !cond_ok;
            if (cond_ok) begin
                st_next.flags = alu_flags;
                if (alu_wr && exec_ctrl.dest_is_pc && (exec_ctrl.op == OP_COPY_OPERAND)) begin
                    st_next.branch_target = {alu_res[DATA_W-1:1], 1'b0};
                    st_next.branch_valid = 1'b1;
                    st_next.status.branch_taken = 1'b1;
                end else if (alu_wr) begin
                    st_next.dest = alu_res;
                    st_next.status.reg_written = 1'b1;
                end
            end
        end
        // Address phase: latch writes, answer reads from the post-write state
        if (wr_take) begin
            st_next.wr_pend = 1'b1;
            st_next.wr_idx = haddr[IDX_MSB:IDX_LSB];
        end
        if (rd_take) begin
            st_next.hrdata = '0;
            if (addr_ok) begin
                unique case (haddr[IDX_MSB:IDX_LSB])
                    IDX_FIRST_SRC: st_next.hrdata = st_next.first_src;
                    IDX_SECOND_SRC: st_next.hrdata = st_next.second_src;
                    IDX_SHIFT_AMT: st_next.hrdata = st_next.shift_amt;
                    IDX_DEST: st_next.hrdata = st_next.dest;
                    IDX_CTRL: st_next.hrdata = st_next.ctrl;
                    IDX_FLAGS: st_next.hrdata = {28'h0000000, st_next.flags};
                    IDX_STATUS: st_next.hrdata = {28'h0000000, st_next.status};
                    IDX_BRANCH: st_next.hrdata = st_next.branch_target;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hrdata = st_reg.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign branch_valid = st_reg.branch_valid;
    assign branch_target = st_reg.branch_target;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_run(logic [4:0] code);
        exec_fire && cond_ok && (exec_ctrl.op == code);
    endsequence

    property p_compare_keeps_dest;
        s_run(OP_COMPARE_SUBTRACT) |=> (st_reg.dest == $past(st_reg.dest))
            && (st_reg.flags.z == ($past(st_reg.first_src) == $past(flex_val)));
    endproperty
    a_compare_keeps_dest: assert property (p_compare_keeps_dest) else $error("compare wrote dest or bad Z");

    property p_cmn_carry;
        s_run(OP_COMPARE_NEGATIVE_ADD) |=> st_reg.flags.c
            == (({1'b0, $past(st_reg.first_src)} + {1'b0, $past(flex_val)}) > 33'h0FFFFFFFF);
    endproperty
    a_cmn_carry: assert property (p_cmn_carry) else $error("compare-negative carry wrong");

    property p_wide_imm;
        s_run(OP_COPY_WIDE_IMMEDIATE) |=> (st_reg.dest[31:16] == 16'h0000)
            && (st_reg.dest[15:0] == $past(st_reg.second_src[15:0])) && $stable(st_reg.flags);
    endproperty
    a_wide_imm: assert property (p_wide_imm) else $error("wide immediate copy wrong");

    property p_upper_half;
        s_run(OP_WRITE_UPPER_HALF) |=> (st_reg.dest[15:0] == $past(st_reg.dest[15:0]))
            && (st_reg.dest[31:16] == $past(st_reg.second_src[15:0])) && $stable(st_reg.flags);
    endproperty
    a_upper_half: assert property (p_upper_half) else $error("upper-half write wrong");

    property p_inverted_flags;
        s_run(OP_COPY_INVERTED) ##0 exec_ctrl.set_flags && !exec_ctrl.dest_is_pc |=>
            (st_reg.dest == ~$past(flex_val)) && (st_reg.flags.n == st_reg.dest[31]) && $stable(st_reg.flags.v);
    endproperty
    a_inverted_flags: assert property (p_inverted_flags) else $error("inverted copy flags wrong");

    sequence s_branch_pulse;
        branch_valid && !branch_target[0] ##1 !branch_valid;
    endsequence

    property p_pc_branch;
        s_run(OP_COPY_OPERAND) ##0 exec_ctrl.dest_is_pc |=> s_branch_pulse;
    endproperty
    a_pc_branch: assert property (p_pc_branch) else $error("copy to PC did not branch once");

    property p_cond_fail;
        exec_fire && !cond_ok |=> $stable(st_reg.dest) && $stable(st_reg.flags) && st_reg.status.cond_failed;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed condition changed state");

    property p_byte_rev;
        s_run(OP_BYTE_REVERSE_WORD) |=> (st_reg.dest[7:0] == $past(st_reg.first_src[31:24]))
            && (st_reg.dest[31:24] == $past(st_reg.first_src[7:0])) && $stable(st_reg.flags);
    endproperty
    a_byte_rev: assert property (p_byte_rev) else $error("word byte reverse wrong");

    property p_bit_rev;
        s_run(OP_BIT_REVERSE_WORD) |=> (st_reg.dest[31] == $past(st_reg.first_src[0]))
            && (st_reg.dest[0] == $past(st_reg.first_src[31]));
    endproperty
    a_bit_rev: assert property (p_bit_rev) else $error("bit reverse wrong");

    property p_byte_lanes;
        s_run(OP_PARALLEL_SIGNED_ADD_BYTES) |=> (st_reg.dest[15:8]
            == 8'($past(st_reg.first_src[15:8]) + $past(st_reg.second_src[15:8]))) && $stable(st_reg.flags);
    endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("byte lane add wrong");

endmodule // cmr_alu

/* tb/cmr_host.sv */
// Bus master model standing in for the core's decoder and register file
`timescale 1ns/1ps
module cmr_host (
    // Clock and bus return
    input wire logic hclk,
    input wire logic hready,
    input wire logic [cmr_pkg::DATA_W-1:0] hrdata,
    // Bus request
    output logic hsel,
    output logic [cmr_pkg::ADDR_W-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [cmr_pkg::DATA_W-1:0] hwdata
);
    import cmr_pkg::*;
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
    end
    // Operands never name stack pointer or program counter
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // cmr_host

/* tb/tb.sv */
// Self-checking testbench of the datapath slice
`timescale 1ns/1ps
module tb;
    import cmr_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, branch_valid;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, branch_target;
    int fail_count, checked;
    initial hclk = 1'b0;
    always #2 hclk = ~hclk;
    cmr_alu cmr_alu_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .branch_valid(branch_valid), .branch_target(branch_target));
    cmr_host cmr_host_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        cmr_host_inst.xfer(1'b1, a, d, q);
    endtask
    task rc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        cmr_host_inst.xfer(1'b0, a, '0, q);
        chk(q, e);
        chk(hresp, 32'(HRESP_OKAY));
    endtask
    // Launch one operation; sh is {shift_by_reg, shift_type}
    task ex(input logic [4:0] op, input logic sf, input logic [3:0] cc, input logic [2:0] sh,
            input logic [4:0] imm, input logic pc = 1'b0);
        cmr_ctrl_t c;
        c = '0;
        c.op = op;
        c.set_flags = sf;
        c.cond = cc;
        c.shift_by_reg = sh[2];
        c.shift_type = sh[1:0];
        c.imm_shift = imm;
        c.dest_is_pc = pc;
        c.go = 1'b1;
        wr(32'h10, c);
    endtask
    task t_compare;
        wr(32'h0, 32'h5);
        wr(32'h4, 32'h5);
        ex(5'h0, 1'b0, 4'hE, 3'h0, 5'h0);
        rc(32'h14, 32'h6);
        rc(32'hC, 32'h0);
        wr(32'h0, 32'h7FFFFFFF);
        wr(32'h4, 32'h1);
        ex(5'h1, 1'b0, 4'hE, 3'h0, 5'h0);
        rc(32'h14, 32'h9);
        rc(32'hC, 32'h0);
        rc(32'h20, 32'h0);
    endtask
    task t_cond;
        wr(32'h4, 32'h5A5A0001);
        ex(5'h2, 1'b0, CC_EQ, 3'h0, 5'h0);
        rc(32'hC, 32'h0);
        rc(32'h18, 32'h8);
        ex(5'h2, 1'b0, CC_MI, 3'h0, 5'h0);
        rc(32'hC, 32'h5A5A0001);
    endtask
    task t_copy;
        wr(32'h4, 32'h80000001);
        ex(5'h2, 1'b1, 4'hE, 3'b011, 5'h1);
        rc(32'hC, 32'hC0000000);
        rc(32'h14, 32'hB);
        ex(5'h3, 1'b1, 4'hE, 3'h0, 5'h0);
        rc(32'hC, 32'h7FFFFFFE);
        rc(32'h14, 32'h3);
        wr(32'h8, 32'd40);
        wr(32'h4, 32'h80000000);
        ex(5'h2, 1'b1, 4'hE, 3'b110, 5'h0);
        rc(32'hC, 32'hFFFFFFFF);
        rc(32'h14, 32'hB);
        wr(32'h4, 32'hABCDFA05);
        ex(5'h4, 1'b1, 4'hE, 3'h0, 5'h0);
        rc(32'hC, 32'h0000FA05);
        rc(32'h14, 32'hB);
        wr(32'h4, 32'h1234F123);
        ex(5'h5, 1'b0, 4'hE, 3'h0, 5'h0);
        rc(32'hC, 32'hF123FA05);
        rc(32'h14, 32'hB);
        wr(32'h14, 32'h0);
        wr(32'h4, 32'h80000001);
        ex(5'h2, 1'b1, 4'hE, 3'b011, 5'h0);
        rc(32'hC, 32'h40000000);
        rc(32'h14, 32'h2);
        wr(32'h8, 32'd32);
        ex(5'h2, 1'b1, 4'hE, 3'b100, 5'h0);
        rc(32'hC, 32'h0);
        rc(32'h14, 32'h6);
        ex(5'h2, 1'b1, 4'hE, 3'b001, 5'h1F);
        rc(32'hC, 32'h1);
        rc(32'h14, 32'h0);
        wr(32'h14, 32'hB);
    endtask
    task t_lanes;
        logic [31:0] exp [8];
        exp = '{32'hF8563412, 32'h3412F856, 32'hFFFFF856, 32'h1F6A2C48,
                32'h923307F7, 32'h913306F7, 32'h491903FB, 32'h481903FB};
        wr(32'h0, 32'h123456F8);
        wr(32'h4, 32'h7FFFB0FF);
        for (int i = 0; i < 8; i++) begin
            ex(5'(6 + i), 1'b0, 4'hE, 3'h0, 5'h0);
            rc(32'hC, exp[i]);
        end
        rc(32'h14, 32'hB);
    endtask
    task t_branch;
        wr(32'h4, 32'h00001235);
        ex(5'h2, 1'b0, 4'hE, 3'h0, 5'h0, 1'b1);
        #1;
        chk(branch_valid, 32'h1);
        chk(branch_target, 32'h1234);
        @(posedge hclk);
        #1;
        chk(branch_valid, 32'h0);
        rc(32'h1C, 32'h1234);
    endtask
    task report_and_stop;
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        fail_count = 0;
        checked = 0;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_compare();
        t_cond();
        t_copy();
        t_lanes();
        t_branch();
        report_and_stop();
    end
endmodule // tb
